/* File: uirq_pkg.sv */
// Constants and carrier types for the interrupt identification and FIFO control block.
// Assumes a single 10 MHz clock domain shared with the receiver and transmitter cores.
package uirq_pkg;

  // ---------------------------------------------------------------------------
  // Clock
  // ---------------------------------------------------------------------------
  localparam int          CLK_PERIOD_NS  = 100;

  // ---------------------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------------------
  localparam logic [31:0] ADDR_RX_TX     = 32'he000c000;
  localparam logic [31:0] ADDR_IRQ_EN    = 32'he000c004;
  localparam logic [31:0] ADDR_ID_FCTRL  = 32'he000c008;
  localparam logic [31:0] ADDR_LINE_STAT = 32'he000c014;

  // ---------------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int          FCTRL_EN_BIT    = 0;
  localparam int          FCTRL_RXRST_BIT = 1;
  localparam int          FCTRL_TXRST_BIT = 2;
  localparam int          FCTRL_TRIG_LSB  = 6;
  localparam logic [7:0]  FCTRL_RESET     = 8'h00;
  localparam int          IEN_RDA_BIT     = 0;
  localparam int          IEN_TX_HOLDING_EMPTY_BIT    = 1;
  localparam int          IEN_RLS_BIT     = 2;
  localparam logic [2:0]  IEN_RESET       = 3'h0;
  localparam logic [7:0]  ID_RESET        = 8'h01;

  // Identification codes, bits 3:1
  localparam logic [2:0]  ID_NONE         = 3'h0;
  localparam logic [2:0]  ID_RLS          = 3'h3;
  localparam logic [2:0]  ID_RDA          = 3'h2;
  localparam logic [2:0]  ID_CTI          = 3'h6;
  localparam logic [2:0]  ID_TX_HOLDING_EMPTY         = 3'h1;

  // Receive trigger thresholds
  localparam logic [4:0]  TRIG_LVL0       = 5'h01;
  localparam logic [4:0]  TRIG_LVL1       = 5'h04;
  localparam logic [4:0]  TRIG_LVL2       = 5'h08;
  localparam logic [4:0]  TRIG_LVL3       = 5'h0e;

  // Time-out formula terms, in receive sample clocks
  localparam logic [11:0] WORD_LEN_BASE   = 12'h005;
  localparam logic [11:0] CTI_WL_MUL      = 12'h007;
  localparam logic [11:0] CTI_WL_SUB      = 12'h002;
  localparam logic [11:0] CTI_SCALE       = 12'h008;
  localparam logic [11:0] CTI_ADD         = 12'h001;
  localparam logic [11:0] START_BITS      = 12'h001;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [31:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } uirq_bus_req_t;

  typedef struct packed {
    logic [7:0] data;
    logic       parityError;
    logic       framingError;
    logic       breakIndication;
  } uirq_rx_char_t;

  typedef struct packed {
    logic overrun;
    logic parityError;
    logic framingError;
    logic breakIndication;
  } uirq_line_err_t;

  typedef enum logic [1:0] {
    THR_FILLED = 2'b00,
    THR_WAIT   = 2'b01,
    THR_EMPTY  = 2'b11
  } uirq_thr_state_t;

endpackage : uirq_pkg

/* File: uirq_fifo.sv */
// Flip-flop FIFO with synchronous clear and fill count.
// Assumes push and pop come from logic on the same clock.
`timescale 1ns/1ns
module uirq_fifo #(
  parameter  int WIDTH = 8,
  parameter  int DEPTH = 16,
  localparam int AW    = $clog2(DEPTH),
  localparam int CW    = AW + 1
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rstSync_n,
  // Fill side
  input  wire logic             clear,
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] pushData,
  // Drain side
  input  wire logic             pop,
  output logic      [WIDTH-1:0] popData,
  // Status
  output logic      [CW-1:0]    count,
  output logic                  full,
  output logic                  empty
);

  // ---------------------------------------------------------------------------
  // Elaboration check
  // ---------------------------------------------------------------------------
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_param
    $error("uirq_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW-1:0]    next_wrPtr;
  logic [AW-1:0]    next_rdPtr;
  logic [CW-1:0]    next_count;
  logic             doPush;
  logic             doPop;

  assign full    = (count == CW'(DEPTH));
  assign empty   = (count == '0);
  assign doPush  = push & ~full & ~clear;
  assign doPop   = pop & ~empty & ~clear;
  assign popData = mem[rdPtr];

  // ---------------------------------------------------------------------------
  // Pointers
  // ---------------------------------------------------------------------------
  always_comb begin
    next_wrPtr = wrPtr;
    next_rdPtr = rdPtr;
    next_count = count;
    if (clear) begin
      next_wrPtr = '0;
      next_rdPtr = '0;
      next_count = '0;
    end else begin
      if (doPush) begin
        next_wrPtr = wrPtr + 1'b1;
      end
      if (doPop) begin
        next_rdPtr = rdPtr + 1'b1;
      end
      next_count = count + CW'(doPush) - CW'(doPop);
    end
  end

  always_ff @(posedge ref_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
    end
  end

  // Storage, no reset needed
  always_ff @(posedge ref_clk) begin
    if (doPush) begin
      mem[wrPtr] <= pushData;
    end
  end

endmodule : uirq_fifo

/* File: uirq_ctrl.sv */
// Interrupt identification, prioritisation and FIFO control of a UART.
// Assumes receiver and transmitter cores on ref_clk; rxSampleTick pulses once per sample clock.
`timescale 1ns/1ns
module uirq_ctrl
  import uirq_pkg::*;
#(
  parameter  int RX_DEPTH      = 16,
  parameter  int TX_DEPTH      = 16,
  parameter  int TICKS_PER_BIT = 16,
  localparam int RCW           = $clog2(RX_DEPTH) + 1,
  localparam int TCW           = $clog2(TX_DEPTH) + 1
) (
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    reset_n,
  // Register port
  input  wire uirq_pkg::uirq_bus_req_t busReq,
  output logic                  [7:0]  busRdata,
  // Receiver core
  input  wire logic                    rxCharValid,
  input  wire uirq_pkg::uirq_rx_char_t rxChar,
  input  wire logic                    rxSampleTick,
  input  wire logic             [1:0]  wordLenSel,
  input  wire logic                    parityOn,
  // Transmitter core
  input  wire logic                    txTaken,
  output logic                         txValid,
  output logic                  [7:0]  txData,
  // Status
  output logic                         irqPending
);

  // ---------------------------------------------------------------------------
  // Elaboration check
  // ---------------------------------------------------------------------------
  if (RX_DEPTH < 16 || TX_DEPTH < 2 || TICKS_PER_BIT < 1 || TICKS_PER_BIT > 64) begin : g_bad_param
    $error("uirq_ctrl: receive depth must hold the top trigger level");
  end

  // ---------------------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------------------
  logic rstMeta_n;
  logic rstSync_n;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta_n <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta_n <= 1'b1;
      rstSync_n <= rstMeta_n;
    end
  end

  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------
  logic wrHolding, wrEnable, wrFifoCtrl;
  logic rdBuffer, rdEnable, rdId, rdLineStat;

  always_comb begin
    wrHolding  = 1'b0;
    wrEnable   = 1'b0;
    wrFifoCtrl = 1'b0;
    rdBuffer   = 1'b0;
    rdEnable   = 1'b0;
    rdId       = 1'b0;
    rdLineStat = 1'b0;
    if (busReq.addr == ADDR_RX_TX) begin
      wrHolding = busReq.wr;
      rdBuffer  = busReq.rd;
    end else if (busReq.addr == ADDR_IRQ_EN) begin
      wrEnable = busReq.wr;
      rdEnable = busReq.rd;
    end else if (busReq.addr == ADDR_ID_FCTRL) begin
      wrFifoCtrl = busReq.wr;
      rdId       = busReq.rd;
    end else if (busReq.addr == ADDR_LINE_STAT) begin
      rdLineStat = busReq.rd;
    end
  end

  // ---------------------------------------------------------------------------
  // FIFO control and enables
  // ---------------------------------------------------------------------------
  logic       fifoEnable, next_fifoEnable;
  logic [1:0] trigSel, next_trigSel;
  logic [2:0] irqEnable, next_irqEnable;
  logic       rxClear, txClear;
  logic [4:0] trigLevel;

  always_comb begin
    next_fifoEnable = fifoEnable;
    next_trigSel    = trigSel;
    next_irqEnable  = irqEnable;
    rxClear         = ~fifoEnable;
    txClear         = ~fifoEnable;
    if (wrFifoCtrl) begin
      next_fifoEnable = busReq.wdata[FCTRL_EN_BIT];
      if (busReq.wdata[FCTRL_EN_BIT] != fifoEnable) begin
        rxClear = 1'b1;
        txClear = 1'b1;
      end
      if (busReq.wdata[FCTRL_EN_BIT]) begin
        next_trigSel = busReq.wdata[FCTRL_TRIG_LSB +: 2];
        if (busReq.wdata[FCTRL_RXRST_BIT]) begin
          rxClear = 1'b1;
        end
        if (busReq.wdata[FCTRL_TXRST_BIT]) begin
          txClear = 1'b1;
        end
      end
    end
    if (wrEnable) begin
      next_irqEnable = busReq.wdata[2:0];
    end
    case (trigSel)
      2'b00:   trigLevel = TRIG_LVL0;
      2'b01:   trigLevel = TRIG_LVL1;
      2'b10:   trigLevel = TRIG_LVL2;
      default: trigLevel = TRIG_LVL3;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      fifoEnable <= FCTRL_RESET[FCTRL_EN_BIT];
      trigSel    <= FCTRL_RESET[FCTRL_TRIG_LSB +: 2];
      irqEnable  <= IEN_RESET;
    end else begin
      fifoEnable <= next_fifoEnable;
      trigSel    <= next_trigSel;
      irqEnable  <= next_irqEnable;
    end
  end

  // ---------------------------------------------------------------------------
  // FIFOs
  // ---------------------------------------------------------------------------
  logic [RCW-1:0] rxCount;
  logic [TCW-1:0] txCount;
  logic           rxFull, rxEmpty, txEmpty;
  logic           rxPush, rxPop, txLoad;
  logic [10:0]    rxHead;
  logic [7:0]     txHead;

  assign rxPush = rxCharValid & ~rxFull & ~rxClear;
  assign rxPop  = rdBuffer & ~rxEmpty & ~rxClear;
  assign txLoad = (~txValid | txTaken) & ~txEmpty & ~txClear;

  uirq_fifo #(.WIDTH(11), .DEPTH(RX_DEPTH)) u_rx_fifo (
    .ref_clk   (ref_clk),
    .rstSync_n (rstSync_n),
    .clear     (rxClear),
    .push      (rxCharValid),
    .pushData  ({rxChar.data, rxChar.parityError, rxChar.framingError, rxChar.breakIndication}),
    .pop       (rdBuffer),
    .popData   (rxHead),
    .count     (rxCount),
    .full      (rxFull),
    .empty     (rxEmpty)
  );

  uirq_fifo #(.WIDTH(8), .DEPTH(TX_DEPTH)) u_tx_fifo (
    .ref_clk   (ref_clk),
    .rstSync_n (rstSync_n),
    .clear     (txClear),
    .push      (wrHolding),
    .pushData  (busReq.wdata),
    .pop       (txLoad),
    .popData   (txHead),
    .count     (txCount),
    .full      (),
    .empty     (txEmpty)
  );

  // ---------------------------------------------------------------------------
  // Line errors
  // ---------------------------------------------------------------------------
  uirq_line_err_t lineErr, next_lineErr;

  always_comb begin
    next_lineErr = rdLineStat ? '0 : lineErr;
    if (rxCharValid && rxFull) begin
      next_lineErr.overrun = 1'b1;
    end
    if (rxPush) begin
      next_lineErr.parityError     = next_lineErr.parityError | rxChar.parityError;
      next_lineErr.framingError    = next_lineErr.framingError | rxChar.framingError;
      next_lineErr.breakIndication = next_lineErr.breakIndication | rxChar.breakIndication;
    end
  end

  always_ff @(posedge ref_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      lineErr <= '0;
    end else begin
      lineErr <= next_lineErr;
    end
  end

  // ---------------------------------------------------------------------------
  // Character time-out
  // ---------------------------------------------------------------------------
  logic [11:0] wordLen, ctiBase, ctiTrig, ctiHeld, ctiPeriod;
  logic [11:0] ctiCnt, next_ctiCnt;
  logic        ctiFlag, next_ctiFlag;

  always_comb begin
    wordLen   = WORD_LEN_BASE + 12'(wordLenSel);
    ctiBase   = (wordLen * CTI_WL_MUL - CTI_WL_SUB) * CTI_SCALE;
    ctiTrig   = 12'(trigLevel) * CTI_SCALE + CTI_ADD;
    ctiHeld   = 12'(rxCount) * CTI_SCALE;
    ctiPeriod = (ctiBase + ctiTrig > ctiHeld) ? ctiBase + ctiTrig - ctiHeld : 12'h001;
    next_ctiCnt  = ctiCnt;
    next_ctiFlag = ctiFlag;
    if (rxPush || rxPop || rxClear || rxEmpty) begin
      next_ctiCnt  = '0;
      next_ctiFlag = 1'b0;
    end else if (rxSampleTick && !ctiFlag) begin
      next_ctiCnt = ctiCnt + 12'h001;
      if (next_ctiCnt >= ctiPeriod) begin
        next_ctiFlag = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      ctiCnt  <= '0;
      ctiFlag <= 1'b0;
    end else begin
      ctiCnt  <= next_ctiCnt;
      ctiFlag <= next_ctiFlag;
    end
  end

  // ---------------------------------------------------------------------------
  // Priority and identification
  // ---------------------------------------------------------------------------
  logic       rlsAct, rdaAct, ctiAct, threAct, anyAct;
  logic       threFlag;
  logic [2:0] idCode;

  always_comb begin
    rlsAct  = irqEnable[IEN_RLS_BIT] & (|lineErr);
    rdaAct  = irqEnable[IEN_RDA_BIT] & (rxCount >= RCW'(trigLevel));
    ctiAct  = irqEnable[IEN_RDA_BIT] & ctiFlag;
    threAct = irqEnable[IEN_TX_HOLDING_EMPTY_BIT] & threFlag;
    anyAct  = rlsAct | rdaAct | ctiAct | threAct;
    if (rlsAct) begin
      idCode = ID_RLS;
    end else if (rdaAct) begin
      idCode = ID_RDA;
    end else if (ctiAct) begin
      idCode = ID_CTI;
    end else if (threAct) begin
      idCode = ID_TX_HOLDING_EMPTY;
    end else begin
      idCode = ID_NONE;
    end
  end

  // ---------------------------------------------------------------------------
  // Transmit-empty with start-up delay
  // ---------------------------------------------------------------------------
  uirq_thr_state_t thrState, next_thrState;
  logic [11:0]     thrCnt, next_thrCnt, thrDelay;
  logic            heldTwo, next_heldTwo, next_threFlag, threSet;

  always_comb begin
    thrDelay      = (START_BITS + wordLen + 12'(parityOn)) * 12'(TICKS_PER_BIT);
    next_thrState = thrState;
    next_thrCnt   = thrCnt;
    next_heldTwo  = heldTwo | (txCount >= TCW'(2));
    threSet       = 1'b0;
    case (thrState)
      THR_FILLED: begin
        if (txEmpty) begin
          next_heldTwo = 1'b0;
          next_thrCnt  = '0;
          if (heldTwo) begin
            threSet       = 1'b1;
            next_thrState = THR_EMPTY;
          end else begin
            next_thrState = THR_WAIT;
          end
        end
      end
      THR_WAIT: begin
        if (!txEmpty) begin
          next_thrState = THR_FILLED;
        end else if (rxSampleTick) begin
          next_thrCnt = thrCnt + 12'h001;
          if (next_thrCnt >= thrDelay) begin
            threSet       = 1'b1;
            next_thrState = THR_EMPTY;
          end
        end
      end
      default: begin
        if (!txEmpty) begin
          next_thrState = THR_FILLED;
        end
      end
    endcase
    // Set beats clear; clear uses the code seen by this read
    next_threFlag = threSet | (threFlag & ~(wrHolding | (rdId & (idCode == ID_TX_HOLDING_EMPTY))));
  end

  always_ff @(posedge ref_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      thrState <= THR_FILLED;
      thrCnt   <= '0;
      heldTwo  <= 1'b0;
      threFlag <= 1'b0;
    end else begin
      thrState <= next_thrState;
      thrCnt   <= next_thrCnt;
      heldTwo  <= next_heldTwo;
      threFlag <= next_threFlag;
    end
  end

  // ---------------------------------------------------------------------------
  // Read data and outputs
  // ---------------------------------------------------------------------------
  logic [7:0] next_busRdata, next_txData;
  logic       next_txValid, next_irqPending;

  always_comb begin
    next_busRdata = 8'h00;
    if (rdBuffer) begin
      next_busRdata = rxEmpty ? 8'h00 : rxHead[10:3];
    end else if (rdEnable) begin
      next_busRdata = {5'h00, irqEnable};
    end else if (rdId) begin
      next_busRdata = {fifoEnable, fifoEnable, 2'b00, idCode, ~anyAct};
    end else if (rdLineStat) begin
      next_busRdata = {1'b0, txEmpty & ~txValid, txEmpty, lineErr.breakIndication,
                       lineErr.framingError, lineErr.parityError, lineErr.overrun, ~rxEmpty};
    end
    next_txValid = txValid & ~txTaken;
    next_txData  = txData;
    if (txLoad) begin
      next_txValid = 1'b1;
      next_txData  = txHead;
    end
    next_irqPending = anyAct;
  end

  always_ff @(posedge ref_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      busRdata   <= 8'h00;
      txValid    <= 1'b0;
      txData     <= 8'h00;
      irqPending <= 1'b0;
    end else begin
      busRdata   <= next_busRdata;
      txValid    <= next_txValid;
      txData     <= next_txData;
      irqPending <= next_irqPending;
    end
  end

endmodule : uirq_ctrl

/* File: uirq_ctrl_sva.sv */
// Port checks for the interrupt and FIFO control block.
// Assumes binding onto uirq_ctrl; sees its ports only.
`timescale 1ns/1ns
module uirq_ctrl_sva
  import uirq_pkg::*;
(
  // Clock and reset
  input wire logic                    ref_clk,
  input wire logic                    reset_n,
  // Watched ports
  input wire uirq_pkg::uirq_bus_req_t busReq,
  input wire logic              [7:0] busRdata,
  input wire logic                    rxCharValid,
  input wire uirq_pkg::uirq_rx_char_t rxChar,
  input wire logic                    irqPending
);
  // ----------
  // Shadow of enables
  // ----------
  logic [2:0] ien;
  logic       fen;
  logic [2:0] next_ien;
  logic       next_fen;
  always_comb begin
    next_ien = ien;
    next_fen = fen;
    if (busReq.wr && busReq.addr == ADDR_IRQ_EN)
      next_ien = busReq.wdata[2:0];
    if (busReq.wr && busReq.addr == ADDR_ID_FCTRL)
      next_fen = busReq.wdata[0];
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ien <= IEN_RESET;
      fen <= 1'b0;
    end else begin
      ien <= next_ien;
      fen <= next_fen;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence id_rd;
    busReq.rd && busReq.addr == ADDR_ID_FCTRL;
  endsequence
  sequence tx_holding_empty_rd;
    busReq.rd && busReq.addr == ADDR_ID_FCTRL && busRdata[3:0] == 4'h2;
  endsequence
  sequence lsr_rd;
    busReq.rd && busReq.addr == ADDR_LINE_STAT && !rxCharValid;
  endsequence
  read_window_a: assert property (!$past(busReq.rd) |-> busRdata == 8'h00)
    else $error("read data outside window");
  id_code_a: assert property (id_rd |=> busRdata[5:0] inside {6'h01, 6'h06, 6'h04, 6'h0c, 6'h02})
    else $error("bad id code");
  id_none_a: assert property (id_rd |=> busRdata[0] == (busRdata[3:1] == 3'h0))
    else $error("pending bit wrong");
  fifo_flag_a: assert property (id_rd |=> busRdata[7:6] == {2{fen}})
    else $error("fifo flag wrong");
  lsr_clear_a: assert property (lsr_rd ##1 lsr_rd |=> busRdata[4:1] == 4'h0)
    else $error("errors not cleared");
  line_irq_a: assert property (rxCharValid && rxChar.framingError && ien[2] && fen |-> ##[1:2] irqPending)
    else $error("line irq missing");
  enable_gate_a: assert property ((ien == 3'h0) [*3] |-> !irqPending)
    else $error("irq while disabled");
  tx_holding_empty_clear_a: assert property (id_rd ##1 tx_holding_empty_rd |=> busRdata[3:0] != 4'h2)
    else $error("tx empty not cleared");
endmodule : uirq_ctrl_sva
bind uirq_ctrl uirq_ctrl_sva i_sva (.ref_clk(ref_clk), .reset_n(reset_n), .busReq(busReq),
  .busRdata(busRdata), .rxCharValid(rxCharValid), .rxChar(rxChar), .irqPending(irqPending));

/* File: uirq_line_model.sv */
// Far side of the serial line: receiver and transmitter cores.
// Assumes one sample tick per clock; stall holds off takes.
`timescale 1ns/1ns
module uirq_line_model
  import uirq_pkg::*;
(
  // Clock
  input wire logic                ref_clk,
  // Transmit side
  input wire logic                txValid,
  input wire logic                stall,
  output logic                    txTaken,
  // Receive side
  output logic                    rxCharValid,
  output uirq_pkg::uirq_rx_char_t rxChar,
  output logic                    rxSampleTick
);
  initial begin
    txTaken = 1'b0;
    rxCharValid = 1'b0;
    rxChar = '0;
    rxSampleTick = 1'b1;
  end
  always @(posedge ref_clk)
    txTaken <= txValid && !txTaken && !stall;
  task automatic send(input logic [7:0] d, input logic fe);
    @(posedge ref_clk);
    rxCharValid <= 1'b1;
    rxChar <= '{d, 1'b0, fe, 1'b0};
    @(posedge ref_clk);
    rxCharValid <= 1'b0;
    rxChar <= '{~d, 1'b1, ~fe, 1'b1};
  endtask : send
endmodule : uirq_line_model

/* File: uirq_ctrl_bench.sv */
// Self-checking bench for the interrupt and FIFO control block.
// Assumes the line model drives the receiver and transmitter ports.
`timescale 1ns/1ns
module uirq_ctrl_bench;
  import uirq_pkg::*;
  typedef struct packed {
    logic [1:0] trig;
    logic [4:0] lvl;
  } uirq_row_t;
  logic          ref_clk;
  logic          reset_n;
  logic          stall;
  uirq_bus_req_t busReq;
  logic    [7:0] busRdata;
  logic          rxCharValid;
  uirq_rx_char_t rxChar;
  logic          rxSampleTick;
  logic          txTaken;
  logic          txValid;
  logic    [7:0] txData;
  logic          irqPending;
  logic    [7:0] d;
  logic    [7:0] e;
  logic    [1:0] wordLenSel;
  int            miscompares = 0;
  int            cmpCount = 0;
  uirq_row_t     rows [4] = '{'{2'h0, 5'h01}, '{2'h1, 5'h04}, '{2'h2, 5'h08}, '{2'h3, 5'h0e}};
  uirq_ctrl i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .busReq(busReq), .busRdata(busRdata),
    .rxCharValid(rxCharValid), .rxChar(rxChar), .rxSampleTick(rxSampleTick), .wordLenSel(wordLenSel),
    .parityOn(1'b0), .txTaken(txTaken), .txValid(txValid), .txData(txData), .irqPending(irqPending));
  uirq_line_model i_line (.ref_clk(ref_clk), .txValid(txValid), .stall(stall), .txTaken(txTaken),
    .rxCharValid(rxCharValid), .rxChar(rxChar), .rxSampleTick(rxSampleTick));
  initial begin
    ref_clk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
  end
  task automatic report_and_stop;
    if (miscompares == 0 && cmpCount > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  task automatic wr(input logic [31:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    busReq <= '{a, v, 1'b1, 1'b0};
    @(posedge ref_clk);
    busReq.wr <= 1'b0;
  endtask : wr
  task automatic rd2(input logic [31:0] a, output logic [7:0] v1, output logic [7:0] v2);
    @(posedge ref_clk);
    busReq <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge ref_clk);
    #1 v1 = busRdata;
    @(posedge ref_clk);
    busReq.rd <= 1'b0;
    #1 v2 = busRdata;
  endtask : rd2
  task automatic rdChk(input logic [31:0] a, input logic [7:0] m, input logic [7:0] x);
    @(posedge ref_clk);
    busReq <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge ref_clk);
    busReq.rd <= 1'b0;
    #1 chk(busRdata & m, x);
  endtask : rdChk
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    report_and_stop();
  end
  initial begin
    reset_n = 1'b0;
    busReq = '0;
    wordLenSel = 2'h3;
    stall = 1'b0;
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    cyc(3);
    rdChk(ADDR_ID_FCTRL, 8'hff, 8'h01);
    rdChk(32'he000c010, 8'hff, 8'h00);
    wr(ADDR_IRQ_EN, 8'h01);
    foreach (rows[i]) begin
      wr(ADDR_ID_FCTRL, {rows[i].trig, 6'h03});
      for (int k = 1; k < rows[i].lvl; k++)
        i_line.send(8'h30, 1'b0);
      rdChk(ADDR_ID_FCTRL, 8'hff, 8'hc1);
      i_line.send(8'h5a, 1'b0);
      cyc(2);
      rdChk(ADDR_ID_FCTRL, 8'hff, 8'hc4);
      rd2(ADDR_RX_TX, d, e);
      chk(d, (rows[i].lvl == 5'h01) ? 8'h5a : 8'h30);
      chk(e, (rows[i].lvl == 5'h01) ? 8'h00 : 8'h30);
      rdChk(ADDR_ID_FCTRL, 8'hff, 8'hc1);
    end
    // ----------
    // Transmit empty: delayed, then immediate
    // ----------
    wr(ADDR_ID_FCTRL, 8'h03);
    wr(ADDR_IRQ_EN, 8'h02);
    cyc(160);
    wr(ADDR_RX_TX, 8'ha5);
    cyc(40);
    rdChk(ADDR_ID_FCTRL, 8'hff, 8'hc1);
    chk(txData, 8'ha5);
    cyc(130);
    rd2(ADDR_ID_FCTRL, d, e);
    chk(d, 8'hc2);
    chk(e, 8'hc1);
    stall <= 1'b1;
    repeat (3) wr(ADDR_RX_TX, 8'h3c);
    stall <= 1'b0;
    for (int n = 0; n < 50 && txValid; n++) begin
      @(posedge ref_clk);
      #1;
    end
    if (txValid !== 1'b0) begin
      miscompares++;
      report_and_stop();
    end
    cyc(2);
    rdChk(ADDR_ID_FCTRL, 8'hff, 8'hc2);
    // ----------
    // Line status over data available
    // ----------
    wr(ADDR_ID_FCTRL, 8'h03);
    wr(ADDR_IRQ_EN, 8'h07);
    i_line.send(8'h3c, 1'b1);
    cyc(2);
    rdChk(ADDR_ID_FCTRL, 8'hff, 8'hc6);
    rd2(ADDR_LINE_STAT, d, e);
    chk(d & 8'h1f, 8'h09);
    chk(e & 8'h1e, 8'h00);
    rdChk(ADDR_ID_FCTRL, 8'hff, 8'hc4);
    // ----------
    // Character time-out, trigger 4, two held
    // ----------
    wr(ADDR_ID_FCTRL, 8'h43);
    wr(ADDR_IRQ_EN, 8'h01);
    i_line.send(8'h11, 1'b0);
    i_line.send(8'h22, 1'b0);
    cyc(420);
    rdChk(ADDR_ID_FCTRL, 8'hff, 8'hc1);
    cyc(40);
    rdChk(ADDR_ID_FCTRL, 8'hff, 8'hcc);
    rdChk(ADDR_RX_TX, 8'hff, 8'h11);
    rdChk(ADDR_ID_FCTRL, 8'hff, 8'hc1);
    // Five-bit words, trigger 4, one held: 289 ticks
    wordLenSel <= 2'h0;
    wr(ADDR_ID_FCTRL, 8'h43);
    i_line.send(8'h44, 1'b0);
    cyc(270);
    rdChk(ADDR_ID_FCTRL, 8'hff, 8'hc1);
    cyc(20);
    rdChk(ADDR_ID_FCTRL, 8'hff, 8'hcc);
    wr(ADDR_ID_FCTRL, 8'h43);
    rdChk(ADDR_LINE_STAT, 8'h01, 8'h00);
    // ----------
    // FIFO resets and disable
    // ----------
    stall <= 1'b1;
    wr(ADDR_RX_TX, 8'h01);
    wr(ADDR_RX_TX, 8'h02);
    rdChk(ADDR_LINE_STAT, 8'h20, 8'h00);
    wr(ADDR_ID_FCTRL, 8'h05);
    rdChk(ADDR_LINE_STAT, 8'h20, 8'h20);
    stall <= 1'b0;
    i_line.send(8'h77, 1'b0);
    wr(ADDR_ID_FCTRL, 8'h00);
    rdChk(ADDR_LINE_STAT, 8'h01, 8'h00);
    rdChk(ADDR_ID_FCTRL, 8'hc0, 8'h00);
    report_and_stop();
  end
endmodule : uirq_ctrl_bench
